// ---- rtl/cusf_pkg.sv ----
/*
 * cusf_pkg: constants shared by the channel unit status flag block:
 * apb register offsets, field positions of the device status word and
 * of the control register, and reset values.
 * assumes: imported whole by each design module of the block.
 */
package cusf_pkg;

  // ------------------------------------------------------------------
  // register map (byte addresses on apb)
  // ------------------------------------------------------------------
  localparam logic [7:0] CUSF_DSW_OFS  = 8'h00; // device_status_word, ro
  localparam logic [7:0] CUSF_CTL_OFS  = 8'h04; // control bits
  localparam logic [7:0] CUSF_LOG_OFS  = 8'h08; // write logs and resets
  localparam logic [7:0] CUSF_TT_OFS   = 8'h0c; // tumble_table entry, ro
  localparam logic [7:0] CUSF_CMD_OFS  = 8'h10; // command_byte_reg, ro

  // ------------------------------------------------------------------
  // device status word fields
  // ------------------------------------------------------------------
  localparam int CUSF_DSW_W       = 16;
  localparam int CUSF_NFLAGS      = 11;         // ten word flags + stack ff
  localparam int CUSF_B_COMMAND_REJECTED    = 0;
  localparam int CUSF_B_STKCOPY   = 1;
  localparam int CUSF_B_COMMAND_CHAINING    = 2;
  localparam int CUSF_B_SELREJ    = 3;
  localparam int CUSF_B_UDEND     = 4;
  localparam int CUSF_B_CDEND     = 5;
  localparam int CUSF_B_ENDING_SEQ_DONE     = 6;
  localparam int CUSF_B_CHAN_INIT_SEQ_DONE      = 7;
  localparam int CUSF_B_BUSY_SENT_FLAG      = 8;
  localparam int CUSF_B_CHANNEL_END_SENT_FLAG    = 9;
  localparam int CUSF_F_STKFF     = 10;         // flag index of the ff
  localparam int CUSF_LOW_W       = 10;         // width of flag field

  // ------------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------------
  localparam int CUSF_C_UNIT_END_ENABLE     = 13;         // unit_end_enable
  localparam int CUSF_C_STKSET    = 0;          // write 1: set stack ff

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [CUSF_NFLAGS-1:0] CUSF_FLAGS_RST = 11'h000;
  localparam logic [15:0]            CUSF_WORD_RST  = 16'h0000;
  localparam logic [7:0]             CUSF_BYTE_RST  = 8'h00;
  localparam logic [31:0]            CUSF_DATA_RST  = 32'h0000_0000;

endpackage : cusf_pkg

// ---- rtl/cusf_sticky.sv ----
/*
 * cusf_sticky: a vector of sticky flags, each set by a one-cycle set
 * term and cleared by a one-cycle clear term.
 * assumes: set and clear are synchronous to clk; set beats clear.
 */
`timescale 1ns/1ns
`default_nettype none

module cusf_sticky
  import cusf_pkg::*;
#(
  parameter int                W   = CUSF_NFLAGS,
  parameter logic [W-1:0]      RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] flags;
  } cusf_sticky_s;

  cusf_sticky_s st_reg;
  cusf_sticky_s st_next;

  // an event in the clearing cycle must survive, so set wins
  always_comb begin
    st_next       = st_reg;
    st_next.flags = (st_reg.flags & ~clr) | set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.flags <= RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.flags;

endmodule // cusf_sticky

`default_nettype wire

// ---- rtl/cusf_status_flags.sv ----
/*
 * cusf_status_flags: low ten bits of the device status word of a channel
 * control unit, the stacked status flip-flop, the command byte, the
 * tumble table entry and an apb slave to reach them.
 * assumes: channel tag events arrive as inputs synchronous to clk; the
 * transfer engine supplies the byte count and transfer state; the apb
 * master follows the usual setup and access phases.
 */
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - set channel end sent flag when channel end status goes out
// - set busy sent flag when a status byte with busy goes out
// - set channel sequence done flag when a channel selection ends
// - clear channel sequence done flag when the word is logged
// - set ending sequence flag on unit status or stacked status taken
// - on address contention set channel sequence flag instead
// - set channel data end when service in is answered by command out
// - interface disconnect also sets it; data end pulses io done, not done
// - clear channel data end once copied into the tumble table
// - byte count zero sets unit data end, interrupt, done, io done
// - with unit end enable, short busy reply sets selection rejected
// - reject only while unit busy and no status pending for address
// - selection rejected survives logging, cleared on unit end taken
// - service out with suppress out on status in sets chaining
// - command out on status in sets stack ff, copy shown at bit 1
// - software may set stack ff only while lockout is low
// - suppress out with stack ff set withdraws request in
// - rejected command sets command rejected, byte kept
// - status word read only, copied to tumble table before reset
module cusf_status_flags
  import cusf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // channel tags seen by the unit
  input  wire logic        command_out,
  input  wire logic        service_out,
  input  wire logic        suppress_out,
  input  wire logic        status_in,
  input  wire logic        service_in,
  // status byte transmission, one-cycle pulse with qualifiers
  input  wire logic        status_xmit,
  input  wire logic        status_is_chan_end,
  input  wire logic        status_is_busy,
  input  wire logic        status_is_cu_end,
  input  wire logic        status_unit_init,
  // selection
  input  wire logic        chan_seq_end,
  input  wire logic        sel_attempt,
  input  wire logic [7:0]  sel_addr,
  input  wire logic [7:0]  req_addr,
  input  wire logic        status_pending,
  input  wire logic        unit_busy_flag,
  input  wire logic        request_status,
  input  wire logic        channel_lockout,
  // command and data transfer
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        cmd_reject,
  input  wire logic        xfer_active,
  input  wire logic        disconnect,
  input  wire logic [15:0] byte_count_reg,
  // outputs
  output logic             request_in,
  output logic             short_busy_reply,
  output logic             io_done,
  output logic             done,
  output logic             program_interrupt,
  output logic      [7:0]  command_byte_reg,
  output logic      [15:0] device_status_word
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        unit_end_enable;
    logic [15:0] dsw;
    logic [15:0] tumble_table;
    logic [7:0]  cmd;
    logic        request_in;
    logic        short_busy;
    logic        io_done;
    logic        done;
    logic        pint;
  } cusf_state_s;

  cusf_state_s st_reg;
  cusf_state_s st_next;

  logic [CUSF_NFLAGS-1:0] flag_q;
  logic [CUSF_NFLAGS-1:0] flag_set;
  logic [CUSF_NFLAGS-1:0] flag_clr;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // status word as the flags stand now
  function automatic logic [15:0] word_of(
    input logic [CUSF_NFLAGS-1:0] f
  );
    logic [15:0] w;
    w = CUSF_WORD_RST;
    w[CUSF_LOW_W-1:0] = f[CUSF_LOW_W-1:0];
    w[CUSF_B_STKCOPY] = f[CUSF_F_STKFF];
    return w;
  endfunction

  // one-hot mask at a flag index
  function automatic logic [CUSF_NFLAGS-1:0] bit_at(input int idx);
    logic [CUSF_NFLAGS-1:0] m;
    m      = CUSF_FLAGS_RST;
    m[idx] = 1'b1;
    return m;
  endfunction

  // ------------------------------------------------------------------
  // flag storage
  // ------------------------------------------------------------------
  cusf_sticky #(
    .W   (CUSF_NFLAGS),
    .RST (CUSF_FLAGS_RST)
  ) u_flags (
    .clk   (clk),
    .rst_n (rst_n),
    .set   (flag_set),
    .clr   (flag_clr),
    .q     (flag_q)
  );

  // ------------------------------------------------------------------
  // event decode
  // ------------------------------------------------------------------
  logic apb_setup;
  logic apb_acc;
  logic wr_log;
  logic wr_ctl;
  logic contention;
  logic sel_reject;
  logic stk_taken;
  logic cue_taken;
  logic chan_dend_ev;
  logic unit_dend_ev;

  // transfer completes at the access edge, which is when pready is high
  assign apb_setup = psel & ~penable;
  assign apb_acc   = psel & penable & st_reg.pready;
  assign wr_log    = apb_acc & pwrite & (paddr == CUSF_LOG_OFS);
  assign wr_ctl    = apb_acc & pwrite & (paddr == CUSF_CTL_OFS);

  // unit status and a channel selection for the same address collide
  assign contention = status_xmit & status_unit_init & request_status &
                      sel_attempt & (sel_addr == req_addr);
  // busy answer only when busy and nothing pending for the address
  assign sel_reject = sel_attempt & unit_busy_flag &
                      ~status_pending;
  assign stk_taken  = status_xmit & flag_q[CUSF_F_STKFF];
  assign cue_taken  = status_xmit & status_is_cu_end;
  assign chan_dend_ev = xfer_active &
    ((service_in & command_out) | disconnect);
  assign unit_dend_ev = xfer_active &
    (byte_count_reg == CUSF_WORD_RST);

  // set terms; pure events, except that unit_end_enable gates selection rejected and contention moves unit status from the ending flag to the sequence flag
  always_comb begin
    flag_set = CUSF_FLAGS_RST;
    if (status_xmit && status_is_chan_end) begin
      flag_set |= bit_at(CUSF_B_CHANNEL_END_SENT_FLAG);
    end
    if (status_xmit && status_is_busy) begin
      flag_set |= bit_at(CUSF_B_BUSY_SENT_FLAG);
    end
    if (chan_seq_end || contention) begin
      flag_set |= bit_at(CUSF_B_CHAN_INIT_SEQ_DONE);
    end
    if ((status_xmit && status_unit_init && !contention) || stk_taken)
    begin
      flag_set |= bit_at(CUSF_B_ENDING_SEQ_DONE);
    end
    if (chan_dend_ev) begin
      flag_set |= bit_at(CUSF_B_CDEND);
    end
    if (unit_dend_ev) begin
      flag_set |= bit_at(CUSF_B_UDEND);
    end
    if (sel_reject && st_reg.unit_end_enable) begin
      flag_set |= bit_at(CUSF_B_SELREJ);
    end
    if (status_in && service_out && suppress_out) begin
      flag_set |= bit_at(CUSF_B_COMMAND_CHAINING);
    end
    if (status_in && command_out) begin
      flag_set |= bit_at(CUSF_F_STKFF);
    end
    // software stacking is refused while the unit holds the channel
    if (wr_ctl && pwdata[CUSF_C_STKSET] && !channel_lockout) begin
      flag_set |= bit_at(CUSF_F_STKFF);
    end
    if (cmd_reject) begin
      flag_set |= bit_at(CUSF_B_COMMAND_REJECTED);
    end
  end

  // clear terms: logging clears the word except the rejected flag and the stack copy
  always_comb begin
    flag_clr = CUSF_FLAGS_RST;
    if (wr_log) begin
      flag_clr[CUSF_LOW_W-1:0] = {CUSF_LOW_W{1'b1}};
      flag_clr[CUSF_B_SELREJ]  = 1'b0;
      flag_clr[CUSF_B_STKCOPY] = 1'b0;     // copy bit is no flag itself
    end
    if (cue_taken) begin
      flag_clr[CUSF_B_SELREJ] = 1'b1;
    end
    if (stk_taken) begin
      flag_clr[CUSF_F_STKFF] = 1'b1;  // stacked status finally taken
    end
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // snapshot of all flags each cycle so reads never tear
    st_next.dsw = word_of(flag_q);

    // log copies the flags exactly as the clear finds them, so an event
    // from the cycle just before the log is filed rather than lost
    if (wr_log) begin
      st_next.tumble_table = word_of(flag_q);
    end

    // only software writes change the enable
    if (wr_ctl) begin
      st_next.unit_end_enable = pwdata[CUSF_C_UNIT_END_ENABLE];
    end

    // last command kept even when rejected
    if (cmd_valid) begin
      st_next.cmd = cmd_byte;
    end

    // withdraw the request for suppressible stacked status
    st_next.request_in = request_status &
      ~(suppress_out & flag_q[CUSF_F_STKFF]);

    st_next.short_busy = sel_reject;

    // io done pulses on the first cycle either data end appears
    st_next.io_done =
      (chan_dend_ev & ~flag_q[CUSF_B_CDEND]) |
      (unit_dend_ev & ~flag_q[CUSF_B_UDEND]);
    st_next.pint = unit_dend_ev & ~flag_q[CUSF_B_UDEND];
    if (unit_dend_ev) begin
      st_next.done = 1'b1;
    end else if (wr_log) begin
      st_next.done = 1'b0;
    end

    // apb: one wait-free access, read data loaded in the setup cycle
    st_next.pready  = 1'b0;
    st_next.pslverr = 1'b0;
    if (apb_setup) begin
      st_next.pready = 1'b1;
      st_next.prdata = CUSF_DATA_RST;
      if (paddr == CUSF_DSW_OFS) begin
        st_next.prdata[15:0] = word_of(flag_q);
        st_next.pslverr = pwrite;              // read only
      end else if (paddr == CUSF_CTL_OFS) begin
        st_next.prdata[CUSF_C_UNIT_END_ENABLE] = st_reg.unit_end_enable;
      end else if (paddr == CUSF_LOG_OFS) begin
        st_next.pslverr = ~pwrite;
      end else if (paddr == CUSF_TT_OFS) begin
        st_next.prdata[15:0] = st_reg.tumble_table;
        st_next.pslverr = pwrite;
      end else if (paddr == CUSF_CMD_OFS) begin
        st_next.prdata[7:0] = st_reg.cmd;
        st_next.pslverr = pwrite;
      end else begin
        st_next.pslverr = 1'b1;         // unmapped: error, reads zero
      end
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.pready          <= 1'b0;
      st_reg.prdata          <= CUSF_DATA_RST;
      st_reg.pslverr         <= 1'b0;
      st_reg.unit_end_enable <= 1'b0;
      st_reg.dsw             <= CUSF_WORD_RST;
      st_reg.tumble_table    <= CUSF_WORD_RST;
      st_reg.cmd             <= CUSF_BYTE_RST;
      st_reg.request_in      <= 1'b0;
      st_reg.short_busy      <= 1'b0;
      st_reg.io_done         <= 1'b0;
      st_reg.done            <= 1'b0;
      st_reg.pint            <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ------------------------------------------------------------------
  assign pready             = st_reg.pready;
  assign prdata             = st_reg.prdata;
  assign pslverr            = st_reg.pslverr;
  assign request_in         = st_reg.request_in;
  assign short_busy_reply   = st_reg.short_busy;
  assign io_done            = st_reg.io_done;
  assign done               = st_reg.done;
  assign program_interrupt  = st_reg.pint;
  assign command_byte_reg   = st_reg.cmd;
  assign device_status_word = st_reg.dsw;

endmodule // cusf_status_flags

`default_nettype wire

// ---- verif/cusf_status_flags_props.sv ----
/*
 * cusf_status_flags_props: timing checks on flags, tags and reads.
 * assumes: bound into cusf_status_flags, ports matched by name.
 */
`timescale 1ns/1ns
`default_nettype none

module cusf_status_flags_props
  import cusf_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        command_out,
  input wire logic        service_out,
  input wire logic        suppress_out,
  input wire logic        status_in,
  input wire logic        service_in,
  input wire logic        status_xmit,
  input wire logic        status_is_chan_end,
  input wire logic        status_is_busy,
  input wire logic        chan_seq_end,
  input wire logic        sel_attempt,
  input wire logic        status_pending,
  input wire logic        unit_busy_flag,
  input wire logic        request_status,
  input wire logic        xfer_active,
  input wire logic        disconnect,
  input wire logic [15:0] byte_count_reg,
  input wire logic        cmd_reject,
  input wire logic        request_in,
  input wire logic        short_busy_reply,
  input wire logic        program_interrupt,
  input wire logic [15:0] device_status_word
);
  // ------------------------------------------------------------------
  // a flag reaches the word two edges after its event
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_dsw_rd;
    pready && !pwrite && paddr == CUSF_DSW_OFS;
  endsequence

  a_channel_end_status_sent: assert property (
    status_xmit && status_is_chan_end |-> ##2 device_status_word[9])
    else $error("bit 9 not set");
  a_busy_sent: assert property (
    status_xmit && status_is_busy |-> ##2 device_status_word[8])
    else $error("bit 8 not set");
  a_seq_done: assert property (
    chan_seq_end |-> ##2 device_status_word[7]) else $error("bit 7 unset");
  a_data_end: assert property (
    xfer_active && (service_in && command_out || disconnect)
    |-> ##2 device_status_word[5]) else $error("bit 5 not set");
  a_unit_dend: assert property (
    xfer_active && byte_count_reg == 16'h0000 |-> ##2 device_status_word[4])
    else $error("bit 4 not set");
  a_irq_cause: assert property (
    program_interrupt |-> $past(xfer_active) && $past(byte_count_reg) == 0)
    else $error("interrupt without zero count");
  a_sel_reject: assert property (
    sel_attempt && unit_busy_flag && !status_pending |=> short_busy_reply)
    else $error("busy reply missing");
  a_rej_cause: assert property (
    short_busy_reply |-> $past(sel_attempt) && $past(unit_busy_flag)
    && !$past(status_pending)) else $error("busy reply without cause");
  a_chain_set: assert property (
    status_in && service_out && suppress_out |-> ##2 device_status_word[2])
    else $error("bit 2 not set");
  a_stack_set: assert property (
    status_in && command_out |-> ##2 device_status_word[1])
    else $error("bit 1 not set");
  a_cmd_rej: assert property (
    cmd_reject |-> ##2 device_status_word[0]) else $error("bit 0 unset");
  a_req_withdraw: assert property (
    suppress_out && device_status_word[1] && !$past(status_xmit)
    |=> !request_in) else $error("request in not withdrawn");
  a_read_snap: assert property (
    s_dsw_rd |-> prdata[15:0] == device_status_word)
    else $error("status read not coherent");
  a_ready_next: assert property (
    s_setup |=> pready) else $error("pready missing after setup");

endmodule // cusf_status_flags_props

bind cusf_status_flags cusf_status_flags_props u_props (.*);

`default_nettype wire

// ---- verif/cusf_chan_model.sv ----
/*
 * cusf_chan_model: channel side of the tag handshake.
 * assumes: tasks are called just after a rising edge of clk.
 */
`timescale 1ns/1ns
`default_nettype none

module cusf_chan_model (
  input  wire logic clk,
  output logic      command_out,
  output logic      service_out,
  output logic      suppress_out,
  output logic      status_in,
  output logic      service_in
);
  logic [4:0] tag_reg = 5'h00; // one-cycle reply, idle low
  logic       sup_reg = 1'b0;  // suppress held as a level

  // tags drop back to idle low between replies, except suppress while hold_sup keeps it high
  assign command_out  = tag_reg[0];
  assign service_out  = tag_reg[1];
  assign suppress_out = tag_reg[2] | sup_reg;
  assign status_in    = tag_reg[3];
  assign service_in   = tag_reg[4];

  // suppress as a level, kept across later replies
  task hold_sup(input logic v);
    sup_reg <= v;
    @(posedge clk);
  endtask

  // 0: count overflow, 1: chaining, 2: status stacked
  task reply(input int k);
    case (k)
      0: tag_reg <= 5'h11;
      1: tag_reg <= 5'h0e;
      default: tag_reg <= 5'h09;
    endcase
    @(posedge clk);
    tag_reg <= 5'h00;
    repeat (3) @(posedge clk);
  endtask
endmodule // cusf_chan_model

`default_nettype wire

// ---- verif/test_channel_unit_status_flags.sv ----
/*
 * test_channel_unit_status_flags: apb and tag sequences with expected
 * status words for the flag block.
 * assumes: pulse outputs are counted rather than caught by timing.
 */
`timescale 1ns/1ns
`default_nettype none

module test_channel_unit_status_flags
  import cusf_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, cmd_byte, sel_addr, req_addr, command_byte_reg;
  logic [31:0] pwdata, prdata;
  logic command_out, service_out, suppress_out, status_in, service_in;
  logic status_xmit, status_is_chan_end, status_is_busy, status_is_cu_end;
  logic status_unit_init, chan_seq_end, sel_attempt, status_pending;
  logic unit_busy_flag, request_status, channel_lockout, cmd_valid;
  logic cmd_reject, xfer_active, disconnect, request_in, short_busy_reply;
  logic io_done, done, program_interrupt;
  logic [15:0] byte_count_reg, device_status_word;
  logic [9:0] ev;
  int checked = 0, fails = 0, n_iod = 0, n_pi = 0, n_sbr = 0;

  // event pulses share one vector so a scenario sets them in one go
  assign {disconnect, cmd_reject, cmd_valid, sel_attempt, chan_seq_end,
          status_unit_init, status_is_cu_end, status_is_busy,
          status_is_chan_end, status_xmit} = ev;

  cusf_status_flags dut (.*);
  cusf_chan_model chan (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // one-cycle outputs are counted, so their exact edge need not be met
  always @(posedge clk) begin
    if (io_done === 1'b1) n_iod++;
    if (program_interrupt === 1'b1) n_pi++;
    if (short_busy_reply === 1'b1) n_sbr++;
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] exp, input logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // the slave sets the pace; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    chk("pready", 1, pready);
    if (!w) chk("prdata", exp, prdata);
    chk("pslverr", err, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // one-cycle event, then idle edges while the word catches up
  task pulse(input logic [9:0] v);
    ev <= v;
    @(posedge clk);
    ev <= 10'h000;
    repeat (3) @(posedge clk);
  endtask

  task final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    fails++;
    final_report;
  end

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, status_pending, unit_busy_flag} = 5'h00;
    {request_status, channel_lockout, xfer_active} = 3'h0;
    {paddr, cmd_byte, pwdata} = '0;
    ev = 10'h000;
    sel_addr = 8'h21;
    req_addr = 8'h21;
    byte_count_reg = 16'h0010;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and refused accesses
    apb(0, CUSF_DSW_OFS, 0, 0, 0);
    apb(0, CUSF_CTL_OFS, 0, 0, 0);
    apb(0, CUSF_TT_OFS, 0, 0, 0);
    apb(0, CUSF_CMD_OFS, 0, 0, 0);
    apb(1, CUSF_DSW_OFS, 32'hffff, 0, 1);
    apb(0, 8'h40, 0, 0, 1);
    apb(0, CUSF_DSW_OFS, 0, 0, 0);
    // status bytes sent and sequence ends, then logging
    pulse(10'h007);
    pulse(10'h011);
    pulse(10'h020);
    apb(0, CUSF_DSW_OFS, 0, 32'h03c0, 0);
    apb(1, CUSF_LOG_OFS, 0, 0, 0);
    apb(0, CUSF_TT_OFS, 0, 32'h03c0, 0);
    apb(0, CUSF_DSW_OFS, 0, 0, 0);
    // unit status meets a selection of the same address
    request_status <= 1'b1;
    pulse(10'h051);
    apb(0, CUSF_DSW_OFS, 0, 32'h0080, 0);
    chk("request_in", 1, request_in);
    apb(1, CUSF_LOG_OFS, 0, 0, 0);
    // data end by overflow, by disconnect, by zero count
    xfer_active <= 1'b1;
    chan.reply(0);
    apb(0, CUSF_DSW_OFS, 0, 32'h0020, 0);
    chk("io_done", 1, n_iod);
    apb(1, CUSF_LOG_OFS, 0, 0, 0);
    pulse(10'h200);
    chk("io_done", 2, n_iod);
    apb(1, CUSF_LOG_OFS, 0, 0, 0);
    apb(0, CUSF_TT_OFS, 0, 32'h0020, 0);
    apb(0, CUSF_DSW_OFS, 0, 0, 0);
    byte_count_reg <= 16'h0000;
    repeat (3) @(posedge clk);
    xfer_active <= 1'b0;
    byte_count_reg <= 16'h0010;
    apb(0, CUSF_DSW_OFS, 0, 32'h0010, 0);
    chk("io_done", 3, n_iod);
    chk("program_interrupt", 1, n_pi);
    chk("done", 1, done);
    apb(1, CUSF_LOG_OFS, 0, 0, 0);
    chk("done", 0, done);
    // chaining, rejected command, stacked status under suppress
    chan.reply(1);
    cmd_byte <= 8'h5a;
    pulse(10'h180);
    chan.reply(2);
    apb(0, CUSF_DSW_OFS, 0, 32'h0007, 0);
    chk("device_status_word", 32'h0007, device_status_word);
    apb(0, CUSF_CMD_OFS, 0, 32'h005a, 0);
    chk("command_byte_reg", 32'h005a, command_byte_reg);
    chan.hold_sup(1);
    @(posedge clk);
    chk("request_in", 0, request_in);
    chan.hold_sup(0);
    @(posedge clk);
    chk("request_in", 1, request_in);
    request_status <= 1'b0;
    apb(1, CUSF_LOG_OFS, 0, 0, 0);
    apb(0, CUSF_DSW_OFS, 0, 32'h0002, 0);
    pulse(10'h001);
    apb(0, CUSF_DSW_OFS, 0, 32'h0040, 0);
    apb(1, CUSF_LOG_OFS, 0, 0, 0);
    // selection refused while busy, unless status is pending
    apb(1, CUSF_CTL_OFS, 32'h2000, 0, 0);
    apb(0, CUSF_CTL_OFS, 0, 32'h2000, 0);
    unit_busy_flag <= 1'b1;
    status_pending <= 1'b1;
    pulse(10'h040);
    chk("short_busy_reply", 0, n_sbr);
    status_pending <= 1'b0;
    pulse(10'h040);
    chk("short_busy_reply", 1, n_sbr);
    apb(1, CUSF_LOG_OFS, 0, 0, 0);
    apb(0, CUSF_DSW_OFS, 0, 32'h0008, 0);
    unit_busy_flag <= 1'b0;
    pulse(10'h009);
    apb(0, CUSF_DSW_OFS, 0, 0, 0);
    // host sets the stack flip-flop only without lockout
    channel_lockout <= 1'b1;
    apb(1, CUSF_CTL_OFS, 32'h0001, 0, 0);
    apb(0, CUSF_DSW_OFS, 0, 0, 0);
    channel_lockout <= 1'b0;
    apb(1, CUSF_CTL_OFS, 32'h0001, 0, 0);
    apb(0, CUSF_DSW_OFS, 0, 32'h0002, 0);
    final_report;
  end
endmodule // test_channel_unit_status_flags

`default_nettype wire
